// *** rtl/ldsf_pkg.sv ***
package ldsf_pkg;
  localparam logic [31:0] LDSF_DISP_MEM_LO = 32'h000a0000;
  localparam logic [31:0] LDSF_DISP_MEM_HI = 32'h000bffff;
  localparam logic [9:0] LDSF_DISP_IO_A_LO = 10'h3b0;
  localparam logic [9:0] LDSF_DISP_IO_A_HI = 10'h3bb;
  localparam logic [9:0] LDSF_DISP_IO_B_LO = 10'h3c0;
  localparam logic [9:0] LDSF_DISP_IO_B_HI = 10'h3df;
  localparam logic [15:0] LDSF_IO_UPPER_ZERO = 16'h0000;
  localparam logic [1:0] LDSF_ALIAS_FREE_BLK = 2'h0;
  localparam logic [5:0] LDSF_ALIAS_ZERO = 6'h00;
  localparam logic LDSF_CTRL_RESET = 1'b0;
  localparam logic LDSF_SERR_IDLE = 1'b1;
  localparam int LDSF_ADDR_W = 32;
endpackage

// *** rtl/ldsf_top.sv ***
// Function
// - Display enable claims A0000-BFFFF memory downstream
// - Display enable forwards 3B0-3BB, 3C0-3DF I/O
// - Ten-bit display decode ignores address bits 15:10
// - Display enable blocks those addresses upstream
// - Display forwarding ignores alias bit and windows
// - Display I/O/memory needs I/O/memory space enable
// - Display disabled: forward only inside windows
// - Alias filter only within window, first 64KB
// - Alias filter blocks upper 768 bytes downstream
// - Alias filter forwards upper 768 bytes upstream
// - Alias filter off: forward whole I/O window
// - Forwarding enabled: secondary error sends message
// - Disabled forwarding still occurs if mask clear
// - Wide decode uses sixteen bits, else ten
`timescale 1ns/100ps
`default_nettype none
module ldsf_top
  import ldsf_pkg::*;
#(
  parameter int ADDR_W = LDSF_ADDR_W
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic LEGACY_DISPLAY_ENABLE,
  input wire logic LEGACY_DISPLAY_WIDE_DECODE,
  input wire logic LEGACY_IO_ALIAS_FILTER_ENABLE,
  input wire logic SYSTEM_ERROR_FORWARD_ENABLE,
  input wire logic SERR_ADV_MASK,
  input wire logic FATAL_SEVERITY,
  input wire logic IO_SPACE_ENABLE,
  input wire logic MEM_SPACE_ENABLE,
  input wire logic [ADDR_W-1:0] IO_BASE,
  input wire logic [ADDR_W-1:0] IO_LIMIT,
  input wire logic [ADDR_W-1:0] MEM_BASE,
  input wire logic [ADDR_W-1:0] MEM_LIMIT,
  input wire logic [ADDR_W-1:0] PMEM_BASE,
  input wire logic [ADDR_W-1:0] PMEM_LIMIT,
  input wire logic DN_REQ_VALID,
  input wire logic DN_REQ_IS_IO,
  input wire logic [ADDR_W-1:0] DN_REQ_ADDR,
  input wire logic UP_REQ_VALID,
  input wire logic UP_REQ_IS_IO,
  input wire logic [ADDR_W-1:0] UP_REQ_ADDR,
  input wire logic SECONDARY_SYSTEM_ERROR_N,
  output logic DN_DONE,
  output logic DN_CLAIM,
  output logic UP_DONE,
  output logic UP_CLAIM,
  output logic ERR_MSG_SEND,
  output logic ERR_MSG_FATAL
);
  if (ADDR_W != 32) begin : g_chk
    $error("ldsf_top supports only ADDR_W of 32");
  end

  logic dn_done_q, dn_done_d, dn_claim_q, dn_claim_d;
  logic up_done_q, up_done_d, up_claim_q, up_claim_d;
  logic err_send_q, err_send_d, err_fatal_q, err_fatal_d;
  logic serr_prev_q, serr_prev_d;

  function automatic logic in_win(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction

  // Legacy display I/O match; narrow mode lets any alias within the first 64 KB through
  function automatic logic disp_io(input logic [31:0] a, input logic wide);
    logic lo_ok;
    lo_ok = ((a[9:0] >= LDSF_DISP_IO_A_LO) && (a[9:0] <= LDSF_DISP_IO_A_HI)) ||
            ((a[9:0] >= LDSF_DISP_IO_B_LO) && (a[9:0] <= LDSF_DISP_IO_B_HI));
    disp_io = (a[31:16] == LDSF_IO_UPPER_ZERO) && lo_ok &&
              (!wide || (a[15:10] == LDSF_ALIAS_ZERO));
  endfunction

  function automatic logic disp_mem(input logic [31:0] a);
    disp_mem = in_win(a, LDSF_DISP_MEM_LO, LDSF_DISP_MEM_HI);
  endfunction

  // Upper 768 bytes of a 1-KB block within the first 64 KB
  function automatic logic isa_alias(input logic [31:0] a);
    isa_alias = (a[31:16] == LDSF_IO_UPPER_ZERO) && (a[9:8] != LDSF_ALIAS_FREE_BLK);
  endfunction

  logic dn_disp, dn_io_win, dn_mem_win, dn_fwd;
  logic up_disp, up_io_win, up_mem_win, up_fwd;
  logic serr_edge;

  always_comb begin
    dn_disp = LEGACY_DISPLAY_ENABLE &&
              (DN_REQ_IS_IO ? disp_io(DN_REQ_ADDR, LEGACY_DISPLAY_WIDE_DECODE) : disp_mem(DN_REQ_ADDR));
    dn_io_win = in_win(DN_REQ_ADDR, IO_BASE, IO_LIMIT);
    dn_mem_win = in_win(DN_REQ_ADDR, MEM_BASE, MEM_LIMIT) || in_win(DN_REQ_ADDR, PMEM_BASE, PMEM_LIMIT);
    if (dn_disp) begin
      dn_fwd = DN_REQ_IS_IO ? IO_SPACE_ENABLE : MEM_SPACE_ENABLE;
    end else if (DN_REQ_IS_IO) begin
      dn_fwd = IO_SPACE_ENABLE && dn_io_win &&
               !(LEGACY_IO_ALIAS_FILTER_ENABLE && isa_alias(DN_REQ_ADDR));
    end else begin
      dn_fwd = MEM_SPACE_ENABLE && dn_mem_win;
    end
    up_disp = LEGACY_DISPLAY_ENABLE &&
              (UP_REQ_IS_IO ? disp_io(UP_REQ_ADDR, LEGACY_DISPLAY_WIDE_DECODE) : disp_mem(UP_REQ_ADDR));
    up_io_win = in_win(UP_REQ_ADDR, IO_BASE, IO_LIMIT);
    up_mem_win = in_win(UP_REQ_ADDR, MEM_BASE, MEM_LIMIT) || in_win(UP_REQ_ADDR, PMEM_BASE, PMEM_LIMIT);
    // Upstream: outside the windows, alias range inside window when filtered, never display
    if (up_disp) begin
      up_fwd = 1'b0;
    end else if (UP_REQ_IS_IO) begin
      up_fwd = !up_io_win || (LEGACY_IO_ALIAS_FILTER_ENABLE && isa_alias(UP_REQ_ADDR));
    end else begin
      up_fwd = !up_mem_win;
    end
    dn_done_d = DN_REQ_VALID;
    dn_claim_d = DN_REQ_VALID && dn_fwd;
    up_done_d = UP_REQ_VALID;
    up_claim_d = UP_REQ_VALID && up_fwd;
    serr_prev_d = SECONDARY_SYSTEM_ERROR_N;
    serr_edge = serr_prev_q && !SECONDARY_SYSTEM_ERROR_N;
    err_send_d = serr_edge && (SYSTEM_ERROR_FORWARD_ENABLE || !SERR_ADV_MASK);
    err_fatal_d = serr_edge ? FATAL_SEVERITY : err_fatal_q;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      dn_done_q <= LDSF_CTRL_RESET;
      dn_claim_q <= LDSF_CTRL_RESET;
      up_done_q <= LDSF_CTRL_RESET;
      up_claim_q <= LDSF_CTRL_RESET;
      err_send_q <= LDSF_CTRL_RESET;
      err_fatal_q <= LDSF_CTRL_RESET;
      serr_prev_q <= LDSF_SERR_IDLE;
    end else begin
      dn_done_q <= dn_done_d;
      dn_claim_q <= dn_claim_d;
      up_done_q <= up_done_d;
      up_claim_q <= up_claim_d;
      err_send_q <= err_send_d;
      err_fatal_q <= err_fatal_d;
      serr_prev_q <= serr_prev_d;
    end
  end

  assign DN_DONE = dn_done_q;
  assign DN_CLAIM = dn_claim_q;
  assign UP_DONE = up_done_q;
  assign UP_CLAIM = up_claim_q;
  assign ERR_MSG_SEND = err_send_q;
  assign ERR_MSG_FATAL = err_fatal_q;

  property p_disp_mem_claim;
    @(posedge SYS_CLK) disable iff (RESET)
    (DN_REQ_VALID && !DN_REQ_IS_IO && LEGACY_DISPLAY_ENABLE && MEM_SPACE_ENABLE &&
     DN_REQ_ADDR >= LDSF_DISP_MEM_LO && DN_REQ_ADDR <= LDSF_DISP_MEM_HI) |=> DN_CLAIM;
  endproperty
  a_disp_mem_claim: assert property (p_disp_mem_claim) else $error("display memory not claimed");

  property p_disp_io_alias;
    @(posedge SYS_CLK) disable iff (RESET)
    (DN_REQ_VALID && DN_REQ_IS_IO && LEGACY_DISPLAY_ENABLE && !LEGACY_DISPLAY_WIDE_DECODE && IO_SPACE_ENABLE &&
     DN_REQ_ADDR[31:16] == LDSF_IO_UPPER_ZERO &&
     DN_REQ_ADDR[9:0] >= LDSF_DISP_IO_B_LO && DN_REQ_ADDR[9:0] <= LDSF_DISP_IO_B_HI) |=> DN_CLAIM;
  endproperty
  a_disp_io_alias: assert property (p_disp_io_alias) else $error("display io alias not claimed");

  property p_wide_rejects_alias;
    @(posedge SYS_CLK) disable iff (RESET)
    (DN_REQ_VALID && DN_REQ_IS_IO && LEGACY_DISPLAY_ENABLE && LEGACY_DISPLAY_WIDE_DECODE &&
     DN_REQ_ADDR[15:10] != LDSF_ALIAS_ZERO && !in_win(DN_REQ_ADDR, IO_BASE, IO_LIMIT)) |=> !DN_CLAIM;
  endproperty
  a_wide_rejects_alias: assert property (p_wide_rejects_alias) else $error("wide decode took alias");

  property p_up_block_disp;
    @(posedge SYS_CLK) disable iff (RESET)
    (UP_REQ_VALID && !UP_REQ_IS_IO && LEGACY_DISPLAY_ENABLE &&
     UP_REQ_ADDR >= LDSF_DISP_MEM_LO && UP_REQ_ADDR <= LDSF_DISP_MEM_HI) |=> UP_DONE && !UP_CLAIM;
  endproperty
  a_up_block_disp: assert property (p_up_block_disp) else $error("display address forwarded upstream");

  property p_space_enable;
    @(posedge SYS_CLK) disable iff (RESET)
    (DN_REQ_VALID && (DN_REQ_IS_IO ? !IO_SPACE_ENABLE : !MEM_SPACE_ENABLE)) |=> !DN_CLAIM;
  endproperty
  a_space_enable: assert property (p_space_enable) else $error("claimed with space disabled");

  property p_alias_block;
    @(posedge SYS_CLK) disable iff (RESET)
    (DN_REQ_VALID && DN_REQ_IS_IO && !LEGACY_DISPLAY_ENABLE && LEGACY_IO_ALIAS_FILTER_ENABLE &&
     DN_REQ_ADDR[31:16] == LDSF_IO_UPPER_ZERO && DN_REQ_ADDR[9:8] != LDSF_ALIAS_FREE_BLK) |=> !DN_CLAIM;
  endproperty
  a_alias_block: assert property (p_alias_block) else $error("alias forwarded downstream");

  property p_window_io;
    @(posedge SYS_CLK) disable iff (RESET)
    (DN_REQ_VALID && DN_REQ_IS_IO && !LEGACY_DISPLAY_ENABLE && !LEGACY_IO_ALIAS_FILTER_ENABLE &&
     IO_SPACE_ENABLE) |=> (DN_CLAIM == $past(dn_io_win));
  endproperty
  a_window_io: assert property (p_window_io) else $error("io window decode wrong");

  property p_serr_fwd;
    @(posedge SYS_CLK) disable iff (RESET)
    ($fell(SECONDARY_SYSTEM_ERROR_N) && (SYSTEM_ERROR_FORWARD_ENABLE || !SERR_ADV_MASK))
      |=> ERR_MSG_SEND ##1 !ERR_MSG_SEND;
  endproperty
  a_serr_fwd: assert property (p_serr_fwd) else $error("error message not sent once");

  property p_serr_suppress;
    @(posedge SYS_CLK) disable iff (RESET)
    (!SYSTEM_ERROR_FORWARD_ENABLE && SERR_ADV_MASK) |=> !ERR_MSG_SEND;
  endproperty
  a_serr_suppress: assert property (p_serr_suppress) else $error("error message not suppressed");

  property p_err_severity;
    @(posedge SYS_CLK) disable iff (RESET)
    ($fell(SECONDARY_SYSTEM_ERROR_N) && (SYSTEM_ERROR_FORWARD_ENABLE || !SERR_ADV_MASK))
      |=> ERR_MSG_FATAL == $past(FATAL_SEVERITY);
  endproperty
  a_err_severity: assert property (p_err_severity) else $error("error message severity wrong");

  property p_up_alias;
    @(posedge SYS_CLK) disable iff (RESET)
    (UP_REQ_VALID && UP_REQ_IS_IO && !LEGACY_DISPLAY_ENABLE && LEGACY_IO_ALIAS_FILTER_ENABLE &&
     UP_REQ_ADDR[31:16] == LDSF_IO_UPPER_ZERO && UP_REQ_ADDR[9:8] != LDSF_ALIAS_FREE_BLK) |=> UP_CLAIM;
  endproperty
  a_up_alias: assert property (p_up_alias) else $error("alias not forwarded upstream");

  property p_dn_answer;
    @(posedge SYS_CLK) disable iff (RESET)
    DN_REQ_VALID |=> DN_DONE;
  endproperty
  a_dn_answer: assert property (p_dn_answer) else $error("downstream request not answered");

  property p_up_answer;
    @(posedge SYS_CLK) disable iff (RESET)
    UP_REQ_VALID |=> UP_DONE;
  endproperty
  a_up_answer: assert property (p_up_answer) else $error("upstream request not answered");
endmodule
`default_nettype wire

// *** testbench/ldsf_pci_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ldsf_pci_model (
  input wire logic req,
  input wire logic is_io,
  input wire logic [31:0] addr,
  input wire logic err,
  output logic up_valid,
  output logic up_is_io,
  output logic [31:0] up_addr,
  output logic serr_n
);
  assign up_valid = req;
  assign up_is_io = req ? is_io : ~is_io;
  // Idle address shows the inverse so a stale value never looks valid
  assign up_addr = req ? addr : ~addr;
  assign serr_n = ~err;
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ldsf_pkg::*;
  logic clk = 0, rst = 1, disp = 0, wide = 0, alias_en = 0, fwd = 0, mask = 1, sev = 0, io_en = 0, mem_en = 0;
  logic dv = 0, dio = 0, ureq = 0, uio = 0, err = 0, uv, uio_w, sn, dd, dc, ud, uc, ems, emf;
  logic [31:0] iob = '1, iol = '0, mb = '1, ml = '0, pmb = '1, pml = '0, da = '0, ua = '0, ua_w;
  int n_errors = 0, samples_checked = 0, cyc = 0;
  always #4 clk = ~clk;
  ldsf_pci_model pci (.req(ureq), .is_io(uio), .addr(ua), .err(err), .up_valid(uv), .up_is_io(uio_w),
    .up_addr(ua_w), .serr_n(sn));
  ldsf_top uut (.SYS_CLK(clk), .RESET(rst), .LEGACY_DISPLAY_ENABLE(disp), .LEGACY_DISPLAY_WIDE_DECODE(wide),
    .LEGACY_IO_ALIAS_FILTER_ENABLE(alias_en), .SYSTEM_ERROR_FORWARD_ENABLE(fwd), .SERR_ADV_MASK(mask),
    .FATAL_SEVERITY(sev), .IO_SPACE_ENABLE(io_en), .MEM_SPACE_ENABLE(mem_en), .IO_BASE(iob), .IO_LIMIT(iol),
    .MEM_BASE(mb), .MEM_LIMIT(ml), .PMEM_BASE(pmb), .PMEM_LIMIT(pml), .DN_REQ_VALID(dv), .DN_REQ_IS_IO(dio),
    .DN_REQ_ADDR(da), .UP_REQ_VALID(uv), .UP_REQ_IS_IO(uio_w), .UP_REQ_ADDR(ua_w), .SECONDARY_SYSTEM_ERROR_N(sn),
    .DN_DONE(dd), .DN_CLAIM(dc), .UP_DONE(ud), .UP_CLAIM(uc), .ERR_MSG_SEND(ems), .ERR_MSG_FATAL(emf));
  task chk(input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task chk_n(input logic [2:0] e, input logic [2:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task dn(input logic io, input logic [31:0] a, input logic e);
    @(negedge clk);
    dv = 1;
    dio = io;
    da = a;
    @(negedge clk);
    dv = 0;
    da = ~a;
    chk(1'b1, dd);
    chk(e, dc);
  endtask
  task up(input logic io, input logic [31:0] a, input logic e);
    @(negedge clk);
    ureq = 1;
    uio = io;
    ua = a;
    @(negedge clk);
    ureq = 0;
    chk(1'b1, ud);
    chk(e, uc);
  endtask
  task serr(input logic s, input logic e);
    logic [2:0] n;
    n = 0;
    @(negedge clk);
    err = 1;
    sev = s;
    repeat (5) begin
      @(negedge clk);
      n = n + {2'b00, ems};
    end
    err = 0;
    repeat (2) @(negedge clk);
    chk_n({2'b00, e}, n);
    if (e) chk(s, emf);
  endtask
  task t_mem;
    disp = 1;
    mem_en = 1;
    dn(0, 32'h000a0000, 1);
    dn(0, 32'h000bffff, 1);
    dn(0, 32'h0009ffff, 0);
    dn(0, 32'h000c0000, 0);
    mem_en = 0;
    dn(0, 32'h000a0000, 0);
    mem_en = 1;
    disp = 0;
    dn(0, 32'h000a0000, 0);
    mb = 32'h000a0000;
    ml = 32'h000affff;
    dn(0, 32'h000a0000, 1);
    mb = '1;
    ml = '0;
    pmb = 32'h000a0000;
    pml = 32'h000affff;
    dn(0, 32'h000a8000, 1);
    dn(0, 32'h000b0000, 0);
    pmb = '1;
    pml = '0;
    $display("test mem done");
  endtask
  task t_b2b;
    disp = 1;
    mem_en = 1;
    @(negedge clk);
    dv = 1;
    dio = 0;
    da = 32'h000a0000;
    @(negedge clk);
    mem_en = 0;
    chk(1'b1, dd);
    chk(1'b1, dc);
    @(negedge clk);
    dv = 0;
    chk(1'b1, dd);
    chk(1'b0, dc);
    @(negedge clk);
    mem_en = 1;
    chk(1'b0, dd);
    chk(1'b0, dc);
    $display("test b2b done");
  endtask
  task t_io;
    disp = 1;
    io_en = 1;
    alias_en = 1;
    dn(1, 32'h000003b0, 1);
    dn(1, 32'h000003bb, 1);
    dn(1, 32'h000003bc, 0);
    dn(1, 32'h000003c0, 1);
    dn(1, 32'h000003df, 1);
    dn(1, 32'h000003e0, 0);
    dn(1, 32'h000103b0, 0);
    dn(1, 32'h0000fbb0, 1);
    wide = 1;
    dn(1, 32'h000007b0, 0);
    dn(1, 32'h000003b0, 1);
    wide = 0;
    io_en = 0;
    dn(1, 32'h000003c0, 0);
    io_en = 1;
    $display("test io done");
  endtask
  task t_up;
    up(0, 32'h000a0000, 0);
    up(1, 32'h000003c0, 0);
    disp = 0;
    up(0, 32'h000a0000, 1);
    up(1, 32'h000003c0, 1);
    $display("test up done");
  endtask
  task t_alias;
    iob = '0;
    iol = 32'h0000ffff;
    alias_en = 0;
    dn(1, 32'h00000100, 1);
    alias_en = 1;
    dn(1, 32'h00000100, 0);
    dn(1, 32'h00000400, 1);
    iol = 32'h0001ffff;
    dn(1, 32'h00010100, 1);
    iol = 32'h0000ffff;
    up(1, 32'h00000100, 1);
    up(1, 32'h00000050, 0);
    $display("test alias done");
  endtask
  task t_err;
    fwd = 1;
    serr(1, 1);
    serr(0, 1);
    fwd = 0;
    serr(1, 0);
    mask = 0;
    serr(0, 1);
    $display("test err done");
  endtask
  task results;
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      results;
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    t_mem;
    t_b2b;
    t_io;
    t_up;
    t_alias;
    t_err;
    results;
  end
endmodule
`default_nettype wire
